// ---- design/amc_pkg.sv ----
// ==========================================================================
// Mode and interface control package
package amc_pkg;

    // Register addresses on the internal register port
    localparam logic [5:0]  ADDR_STATUS      = 6'h00;
    localparam logic [5:0]  ADDR_OPMODE      = 6'h01;
    localparam logic [5:0]  ADDR_IFOPT       = 6'h02;
    localparam logic [5:0]  ADDR_DATA        = 6'h04;

    // Reset values
    localparam logic [15:0] OPMODE_RESET     = 16'h8000;
    localparam logic [15:0] IFOPT_RESET      = 16'h0000;

    // Writable bit masks; reserved bits are held at zero
    localparam logic [15:0] OPMODE_WMASK     = 16'hA77C;
    localparam logic [15:0] IFOPT_WMASK      = 16'h1DE0;

    // Field positions
    localparam int OPM_REF_EN   = 15;
    localparam int OPM_SINGLE_CYCLE_SETTLING = 13;
    localparam int OPM_DLY_LO   = 8;
    localparam int OPM_MODE_LO  = 4;
    localparam int OPM_CLK_LO   = 2;
    localparam int IFO_ALTERNATE_SYNC_PIN = 12;
    localparam int IFO_HIDE_DLY = 10;
    localparam int STS_RDY      = 7;

    // Operating mode codes
    localparam logic [2:0] MODE_CONT    = 3'h0;
    localparam logic [2:0] MODE_SINGLE  = 3'h1;
    localparam logic [2:0] MODE_STANDBY = 3'h2;
    localparam logic [2:0] MODE_PWRDN   = 3'h3;
    localparam logic [2:0] MODE_CAL_IO  = 3'h4;
    localparam logic [2:0] MODE_CAL_SO  = 3'h6;
    localparam logic [2:0] MODE_CAL_SG  = 3'h7;

    // Clock source codes
    localparam logic [1:0] CLK_INT      = 2'h0;
    localparam logic [1:0] CLK_INT_OUT  = 2'h1;
    localparam logic [1:0] CLK_EXT      = 2'h2;
    localparam logic [1:0] CLK_XTAL     = 2'h3;

    // Clock rate and switch delays
    localparam int CLK_MHZ = 250;
    localparam int DLY_US [8] = '{0, 4, 16, 40, 100, 200, 500, 1000};

    // Register write/read request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } amc_req_t;

    // Decoded control outputs
    typedef struct packed {
        logic       ref_en;
        logic       osc_en;
        logic       osc_out;
        logic       ext_clk;
        logic       xtal;
        logic       alternate_sync_pin;
    } amc_ctl_t;

endpackage : amc_pkg

// ---- design/amc_ctrl.sv ----
// Operation
// - Mode write resets filter, ready flag idles
// - Mode write starts fresh conversion or calibration
// - Mode register resets to 0x8000
// - Bit 15 enables reference and its output
// - Single-cycle settling gives settled-rate results only on one channel
// - Wait programmed delay after channel switch
// - Delay codes map to 0..1 ms
// - Mode codes continuous, single, standby, power-down
// - Codes 100,110,111 start calibrations
// - Clock source field selects clock
// - Internal clock codes switch oscillator on
// - Reserved mode register bits read zero
// - Interface register resets to zero
// - Bit 12 selects alternate sync-pin behaviour
// - Interface bits 15..13 read zero
// - Ready low on result, high on read
// - Ready low when calibration result written
// - Delay hiding absorbs delay into conversion
`timescale 1ns/1ns
`default_nettype none
module amc_ctrl
    import amc_pkg::*;
#(
    parameter int CONV_CYCLES = 64,
    parameter int CAL_CYCLES  = 256,
    parameter int SETTLE_CONV = 3,
    parameter int DLY_SCALE   = 1
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire amc_req_t    i_req,
    input  wire logic        i_multi_channel,
    input  wire logic        i_channel_switch,
    output logic [15:0]      o_rdata,
    output amc_ctl_t         o_ctl,
    output logic             o_filter_reset,
    output logic             o_result_valid,
    output logic             o_cal_done,
    output logic             o_busy
);

    // ======================================================================
    // Parameter checks, refused at elaboration
    localparam int CW = 24;

    // Conversion and calibration phases count down to zero in a CW-bit
    // counter, so each needs two cycles at least and must fit the counter
    if (CONV_CYCLES < 2 || CONV_CYCLES > 2 ** CW) begin : g_bad_conv
        $error("amc_ctrl: CONV_CYCLES out of range");
    end

    if (CAL_CYCLES < 2 || CAL_CYCLES > 2 ** CW) begin : g_bad_cal
        $error("amc_ctrl: CAL_CYCLES out of range");
    end

    // The settling counter is eight bits wide
    if (SETTLE_CONV < 1 || SETTLE_CONV > 2 ** 8) begin : g_bad_settle
        $error("amc_ctrl: SETTLE_CONV out of range");
    end

    // The longest switch delay must still fit the counter once scaled
    if (DLY_SCALE < 1 || (DLY_US[7] * CLK_MHZ) / DLY_SCALE >= 2 ** CW) begin : g_bad_scale
        $error("amc_ctrl: DLY_SCALE out of range");
    end

    // ======================================================================
    // Switch delay table in cycles; DLY_SCALE lets simulation shrink the
    // long waits, at the cost of rounding down when it does not divide
    function automatic logic [CW-1:0] dly_cycles(input logic [2:0] code);
        dly_cycles = CW'((DLY_US[code] * CLK_MHZ) / DLY_SCALE);
    endfunction : dly_cycles

    typedef enum logic [2:0] {AMC_IDLE, AMC_DELAY, AMC_CONV, AMC_CAL} amc_state_t;

    // ======================================================================
    // Stored registers and their write strobes
    logic [15:0]   opmode_r;
    logic [15:0]   ifopt_r;
    logic          wr_mode;
    logic          wr_ifopt;

    // Sequencer state and phase counter
    amc_state_t    state_r;
    amc_state_t    state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          done_conv;
    logic          done_cal;

    // Settling, ready flag and decoded fields
    logic [7:0]    settle_r;
    logic          publish;
    logic          rdy_n_r;
    logic [2:0]    mode;
    logic [1:0]    clksel;

    // Only the two mapped addresses write; every other write is dropped
    assign wr_mode  = i_req.wr && (i_req.addr == ADDR_OPMODE);
    assign wr_ifopt = i_req.wr && (i_req.addr == ADDR_IFOPT);
    assign mode     = opmode_r[OPM_MODE_LO +: 3];
    assign clksel   = opmode_r[OPM_CLK_LO +: 2];

    // ======================================================================
    // Operating-mode register; reserved bits are masked so they read zero
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            opmode_r <= OPMODE_RESET;
        end else if (wr_mode) begin
            opmode_r <= i_req.wdata & OPMODE_WMASK;
        end
    end

    // Interface-options register; it never restarts the sequencer
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ifopt_r <= IFOPT_RESET;
        end else if (wr_ifopt) begin
            ifopt_r <= i_req.wdata & IFOPT_WMASK;
        end
    end

    // ======================================================================
    // Conversion sequencer
    //   IDLE  : standby, power-down, undefined code, finished single shot or calibration
    //   DELAY : switch delay counting down before the input is sampled
    //   CONV  : one raw conversion; its end may publish a result
    //   CAL   : one calibration; its end always lowers the ready flag
    // A mode write always restarts from the top, so a conversion that would
    // have ended in the same cycle is dropped rather than half published
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        done_conv = 1'b0;
        done_cal  = 1'b0;
        if (wr_mode) begin
            // Decode the new mode straight from the write data
            unique case (i_req.wdata[OPM_MODE_LO +: 3])
                MODE_CONT, MODE_SINGLE: begin
                    state_nxt = AMC_DELAY;
                    cnt_nxt   = dly_cycles(i_req.wdata[OPM_DLY_LO +: 3]);
                end
                MODE_CAL_IO, MODE_CAL_SO, MODE_CAL_SG: begin
                    state_nxt = AMC_CAL;
                    cnt_nxt   = CW'(CAL_CYCLES - 1);
                end
                default: begin
                    // Standby, power-down and undefined 101 stop the sequencer
                    state_nxt = AMC_IDLE;
                    cnt_nxt   = '0;
                end
            endcase
        end else begin
            unique case (state_r)
                AMC_IDLE: ;
                AMC_DELAY: begin
                    if (cnt_r == '0) begin
                        state_nxt = AMC_CONV;
                        cnt_nxt   = CW'(CONV_CYCLES - 1);
                    end else begin
                        cnt_nxt = cnt_r - CW'(1);
                    end
                end
                AMC_CONV: begin
                    if (cnt_r == '0) begin
                        done_conv = 1'b1;
                        if (mode == MODE_SINGLE && publish) begin
                            state_nxt = AMC_IDLE;
                        end else if (i_channel_switch && !ifopt_r[IFO_HIDE_DLY]) begin
                            state_nxt = AMC_DELAY;
                            cnt_nxt   = dly_cycles(opmode_r[OPM_DLY_LO +: 3]);
                        end else begin
                            cnt_nxt = CW'(CONV_CYCLES - 1);
                        end
                    end else begin
                        cnt_nxt = cnt_r - CW'(1);
                    end
                end
                AMC_CAL: begin
                    if (cnt_r == '0) begin
                        done_cal  = 1'b1;
                        state_nxt = AMC_IDLE;
                    end else begin
                        cnt_nxt = cnt_r - CW'(1);
                    end
                end
                default: state_nxt = AMC_IDLE;
            endcase
        end
    end

    // Sequencer state and phase counter; both are set to idle values only
    // on reset, since a write restarts them through the next-state logic
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= AMC_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ======================================================================
    // Settling counter: with single-cycle settling on one channel, only
    // every SETTLE_CONV-th raw result is a settled one and is published.
    // With several channels every conversion is published and the bit
    // has no effect, so the host need not clear it when scanning
    assign publish = !(opmode_r[OPM_SINGLE_CYCLE_SETTLING] && !i_multi_channel)
                     || (settle_r >= 8'(SETTLE_CONV - 1));

    // Raw results since the last published one; a mode write restarts the
    // count so a new setting never inherits a partly settled filter
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_r <= '0;
        end else if (wr_mode || (done_conv && publish)) begin
            settle_r <= '0;
        end else if (done_conv) begin
            settle_r <= settle_r + 8'h01;
        end
    end

    // ======================================================================
    // Ready flag (active low); new result beats a same-cycle data read.
    // A mode write never meets a result edge, since the sequencer drops
    // the ending conversion on a write, so the clear cannot hide a result
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdy_n_r <= 1'b1;
        end else if ((done_conv && publish) || done_cal) begin
            rdy_n_r <= 1'b0;
        end else if (wr_mode) begin
            rdy_n_r <= 1'b1;
        end else if (i_req.rd && i_req.addr == ADDR_DATA) begin
            rdy_n_r <= 1'b1;
        end
    end

    // ======================================================================
    // Event outputs, one cycle wide and registered so that they line up
    // with the register contents that the same write has just changed
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_filter_reset <= 1'b0;
            o_result_valid <= 1'b0;
            o_cal_done     <= 1'b0;
        end else begin
            o_filter_reset <= wr_mode;
            o_result_valid <= done_conv && publish;
            o_cal_done     <= done_cal;
        end
    end

    // Busy while any phase runs; in single-shot and calibration modes a host may poll this instead of the flag
    assign o_busy = (state_r != AMC_IDLE);

    // ======================================================================
    // Reference and clock controls follow the stored registers directly.
    // The external and crystal codes leave the oscillator off; switching
    // between sources is glitch-free only if the clock block handles it
    always_comb begin
        o_ctl          = '0;
        o_ctl.ref_en   = opmode_r[OPM_REF_EN];
        o_ctl.alternate_sync_pin = ifopt_r[IFO_ALTERNATE_SYNC_PIN];
        unique case (clksel)
            CLK_INT: begin
                o_ctl.osc_en  = 1'b1;
            end
            CLK_INT_OUT: begin
                o_ctl.osc_en  = 1'b1;
                o_ctl.osc_out = 1'b1;
            end
            CLK_EXT: begin
                o_ctl.ext_clk = 1'b1;
            end
            CLK_XTAL: begin
                o_ctl.xtal    = 1'b1;
            end
        endcase
    end

    // ======================================================================
    // Read data mux, registered; unmapped addresses read zero. The data
    // word itself lives in the filter path, so its read only clears the
    // ready flag here and returns zero on this port
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_req.rd) begin
            unique case (i_req.addr)
                ADDR_STATUS: o_rdata <= 16'(rdy_n_r) << STS_RDY;
                ADDR_OPMODE: o_rdata <= opmode_r;
                ADDR_IFOPT:  o_rdata <= ifopt_r;
                default:     o_rdata <= 16'h0000;
            endcase
        end
    end

endmodule : amc_ctrl
`default_nettype wire

// ---- verif/amc_ctrl_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Port checker for the mode and interface control block
module amc_ctrl_sva
    import amc_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire amc_req_t    i_req,
    input wire logic [15:0] o_rdata,
    input wire amc_ctl_t    o_ctl,
    input wire logic        o_filter_reset,
    input wire logic        o_result_valid,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Register writes seen at the port
    sequence s_mode_wr;
        i_req.wr && i_req.addr == ADDR_OPMODE;
    endsequence
    sequence s_if_wr;
        i_req.wr && i_req.addr == ADDR_IFOPT;
    endsequence
    AST_FILT_RST: assert property (s_mode_wr |=> o_filter_reset)
        else $error("filter reset missing after mode write");
    AST_FILT_CAUSE: assert property (o_filter_reset |-> $past(i_req.wr)
        && $past(i_req.addr) == ADDR_OPMODE) else $error("filter reset without mode write");
    AST_START: assert property ((s_mode_wr and i_req.wdata[6:4] == MODE_CONT)
        |=> o_busy [*2]) else $error("conversion not started");
    AST_STANDBY: assert property ((s_mode_wr and i_req.wdata[6:4] == MODE_STANDBY)
        |=> !o_result_valid [*8]) else $error("result in standby");
    AST_REF_EN: assert property (s_mode_wr |=> o_ctl.ref_en == $past(i_req.wdata[15]))
        else $error("reference enable wrong");
    AST_OSC_ON: assert property (o_ctl.osc_en == !(o_ctl.ext_clk || o_ctl.xtal))
        else $error("oscillator enable wrong");
    AST_CLK_SEL: assert property (s_mode_wr |=>
        o_ctl.osc_out == ($past(i_req.wdata[3:2]) == CLK_INT_OUT)
        && o_ctl.ext_clk == ($past(i_req.wdata[3:2]) == CLK_EXT)
        && o_ctl.xtal == ($past(i_req.wdata[3:2]) == CLK_XTAL)) else $error("clock select wrong");
    AST_ALTERNATE_SYNC_PIN: assert property (s_if_wr |=> o_ctl.alternate_sync_pin == $past(i_req.wdata[12]))
        else $error("alternate sync wrong");
    AST_RSV_OPM: assert property (i_req.rd && i_req.addr == ADDR_OPMODE
        |=> (o_rdata & 16'h5883) == 16'h0000) else $error("mode reserved bits set");
    AST_RSV_IFO: assert property (i_req.rd && i_req.addr == ADDR_IFOPT
        |=> o_rdata[15:13] == 3'h0) else $error("interface reserved bits set");
    AST_PULSE: assert property (o_result_valid |=> !o_result_valid)
        else $error("result pulse too long");
endmodule : amc_ctrl_sva
`default_nettype wire

// ---- verif/amc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Host model: issues one register request per call, just after an edge
module amc_host
    import amc_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic [15:0] i_rdata,
    output var amc_req_t    o_req
);
    initial o_req = '0;
    // Write is taken at the next edge, then released
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        #1 o_req = {1'b1, 1'b0, a, d};
        @(posedge i_sys_clk);
        #1 o_req = '0;
    endtask : wr
    // Read data is registered on the taking edge; sampled one edge later
    task automatic rd(input logic [5:0] a, output logic [15:0] q);
        @(posedge i_sys_clk);
        #1 o_req = {1'b0, 1'b1, a, 16'h0000};
        @(posedge i_sys_clk);
        #1 o_req = '0;
        @(posedge i_sys_clk);
        #1 q = i_rdata;
    endtask : rd
endmodule : amc_host
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Self-checking bench with an integer model of the registers
module testbench
    import amc_pkg::*;
;
    localparam int SCALE = 100;
    logic clk = 0, rst_n = 0, multi = 0, sw = 0, rv, cd, frst, busy;
    logic [15:0] rdata, q, d;
    amc_req_t req;
    amc_ctl_t ctl;
    logic [2:0] cal_codes [3] = '{MODE_CAL_IO, MODE_CAL_SO, MODE_CAL_SG};
    int n_mismatch = 0, checked = 0, opm = 'h8000, ifo = 0, rdy = 1, n, n0, p;
    always #2 clk = ~clk;
    amc_ctrl #(.CONV_CYCLES(16), .CAL_CYCLES(16), .SETTLE_CONV(3), .DLY_SCALE(SCALE)) uut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_multi_channel(multi),
        .i_channel_switch(sw), .o_rdata(rdata), .o_ctl(ctl), .o_filter_reset(frst),
        .o_result_valid(rv), .o_cal_done(cd), .o_busy(busy));
    amc_host hst (.i_sys_clk(clk), .i_rdata(rdata), .o_req(req));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Model follows every write: reserved bits dropped, ready flag idles on a mode write
    task automatic wm(input logic [5:0] a, input logic [15:0] v);
        hst.wr(a, v);
        if (a == ADDR_OPMODE) begin
            opm = v & OPMODE_WMASK;
            rdy = 1;
        end
        if (a == ADDR_IFOPT) ifo = v & IFOPT_WMASK;
    endtask : wm
    task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
        hst.rd(a, q);
        chk("rdata", e, q);
    endtask : rdchk
    // Bounded wait for a result (sel 0) or calibration (sel 1) pulse
    task automatic wait_pulse(input int sel, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (!(sel ? cd : rv) && k < 5000);
        if (k >= 5000) chk("timeout", 16'h0000, 16'h0001);
    endtask : wait_pulse
    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // Watchdog sized well above the longest delay sweep
    initial begin
        #100000 n_mismatch++;
        wrap_up();
    end
    // ======================================================================
    // Main sequence
    initial begin
        void'($urandom(91));
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        rdchk(ADDR_OPMODE, 16'h8000);
        rdchk(ADDR_IFOPT, 16'h0000);
        rdchk(ADDR_STATUS, 16'h0080);
        chk("ctl", 16'h0030, {10'h000, ctl});
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            d[6:4] = MODE_STANDBY; // Never the undefined code
            d[3:2] = i[1:0];
            sw = 1'($urandom);
            wm(ADDR_OPMODE, d);
            rdchk(ADDR_OPMODE, opm[15:0]);
            wm(ADDR_IFOPT, 16'($urandom));
            rdchk(ADDR_IFOPT, ifo[15:0]);
            chk("ctl", {10'h000, opm[15], i < 2, i == 1, i == 2, i == 3, ifo[12]},
                {10'h000, ctl});
            chk("busy", 16'h0000, {15'h0000, busy});
        end
        sw = 0;
        wm(ADDR_OPMODE, 16'h8000);
        wait_pulse(0, n);
        rdy = 0;
        rdchk(ADDR_STATUS, {8'h00, rdy[0], 7'h00});
        hst.rd(ADDR_DATA, q);
        rdy = 1;
        rdchk(ADDR_STATUS, {8'h00, rdy[0], 7'h00});
        wait_pulse(0, n);
        wm(ADDR_OPMODE, 16'h8000);
        chk("filter", 16'h0001, {15'h0000, frst});
        rdchk(ADDR_STATUS, {8'h00, rdy[0], 7'h00});
        // Each calibration code ends with the ready flag low
        foreach (cal_codes[j]) begin
            wm(ADDR_OPMODE, {9'h100, cal_codes[j], 4'h0});
            wait_pulse(1, n);
            rdchk(ADDR_STATUS, 16'h0000);
        end
        // Single conversions: extra latency equals the selected delay
        for (int c = 0; c < 8; c++) begin
            wm(ADDR_OPMODE, {5'h10, c[2:0], 1'b0, MODE_SINGLE, 4'h0});
            wait_pulse(0, n);
            if (c == 0) n0 = n;
            chk("delay", 16'(DLY_US[c] * CLK_MHZ / SCALE), 16'(n - n0));
            hst.rd(ADDR_DATA, q);
            chk("busy", 16'h0000, {15'h0000, busy});
        end
        // Settled-rate output only when a single channel is active
        multi = 1;
        wm(ADDR_OPMODE, 16'hA000);
        wait_pulse(0, n);
        wait_pulse(0, p);
        multi = 0;
        wm(ADDR_OPMODE, 16'hA000);
        wait_pulse(0, n);
        wait_pulse(0, n);
        chk("interval", 16'(3 * p), 16'(n));
        // Channel switches: the programmed delay is inserted unless hidden
        sw = 1;
        wm(ADDR_IFOPT, 16'h0000);
        wm(ADDR_OPMODE, 16'h8000);
        wait_pulse(0, n);
        wait_pulse(0, n0);
        wm(ADDR_OPMODE, 16'h8200);
        wait_pulse(0, n);
        wait_pulse(0, n);
        chk("switch", 16'(DLY_US[2] * CLK_MHZ / SCALE), 16'(n - n0));
        wm(ADDR_IFOPT, 16'h0400);
        wait_pulse(0, n);
        wait_pulse(0, n);
        chk("hidden", 16'(p), 16'(n));
        wrap_up();
    end
endmodule : testbench
bind amc_ctrl amc_ctrl_sva chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .o_rdata(o_rdata), .o_ctl(o_ctl), .o_filter_reset(o_filter_reset),
    .o_result_valid(o_result_valid), .o_busy(o_busy));
`default_nettype wire
